/* core/cisp_pkg.sv */
// Shared constants of the camera isochronous stream packetizer.
package cisp_pkg;
    // ==========================================
    // Clock and bus cycle timing
    // ==========================================
    localparam int unsigned CLK_HZ     = 40_000_000;
    localparam int unsigned CYCLE_NS   = 125_000;
    localparam int unsigned CYCLE_CLKS = CYCLE_NS / (1_000_000_000 / CLK_HZ);

    // ==========================================
    // Link address layout
    // ==========================================
    localparam int unsigned  BUS_W       = 10;
    localparam int unsigned  NODE_W      = 6;
    localparam logic [15:0]  ADDR_ONES   = 16'hFFFF;
    localparam logic [31:0]  CSR_BASE    = 32'hF0F00000;
    localparam logic [11:0]  OFS_STREAM  = 12'h614;
    localparam logic [11:0]  OFS_WINDOW  = 12'hA08;
    localparam logic [11:0]  OFS_PAYLOAD = 12'hA0C;
    localparam logic [11:0]  OFS_IMAGE   = 12'hA10;
    localparam logic [11:0]  OFS_STATUS  = 12'hA14;

    // Registers are big endian: bit 0 is the most significant bit.
    localparam int unsigned  BIT_STREAM  = 31;
    localparam int unsigned  BIT_MIRROR  = 31;
    localparam logic [15:0]  MAX_PAYLOAD = 16'h2000;
    localparam logic [15:0]  MAX_PACKETS = 16'hFFFF;

    // ==========================================
    // Pixel formats, coded in the low bits of the image register
    // ==========================================
    localparam logic [2:0] FMT_MONO_8BIT_FORMAT  = 3'h0;
    localparam logic [2:0] FMT_MONO12 = 3'h1;
    localparam logic [2:0] FMT_MONO16 = 3'h2;
    localparam logic [2:0] FMT_YUV422 = 3'h3;
    localparam logic [2:0] FMT_YUV411 = 3'h4;
    localparam logic [2:0] FMT_RGB_24BIT_FORMAT   = 3'h5;

    // Bytes per pixel, counted in half bytes so that 1.5 stays exact.
    function automatic logic [2:0] cisp_half_bpp(input logic [2:0] fmt);
        case (fmt)
            FMT_MONO12, FMT_YUV411: cisp_half_bpp = 3'h3;
            FMT_MONO16, FMT_YUV422: cisp_half_bpp = 3'h4;
            FMT_RGB_24BIT_FORMAT:               cisp_half_bpp = 3'h6;
            default:                cisp_half_bpp = 3'h2;
        endcase
    endfunction

    // ==========================================
    // Host controller APB map
    // ==========================================
    localparam logic [7:0] HOST_CTRL   = 8'h00;
    localparam logic [7:0] HOST_ADDR   = 8'h04;
    localparam logic [7:0] HOST_WDATA  = 8'h08;
    localparam logic [7:0] HOST_RDATA  = 8'h0C;
    localparam logic [7:0] HOST_STATUS = 8'h10;
    localparam logic [7:0] HOST_WORDS  = 8'h14;
    localparam logic [7:0] HOST_NODE   = 8'h18;
    localparam int unsigned CTRL_GO    = 0;
    localparam int unsigned CTRL_WR    = 1;
    localparam int unsigned CTRL_CYC   = 2;
endpackage

/* core/cisp_link_if.sv */
// Link between the camera and its host controller.
`timescale 1ns/1ps
interface cisp_link_if;
    logic        req;
    logic        wr;
    logic [63:0] addr;
    logic [31:0] wdata;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
    logic        cyc;
    logic        pv;
    logic        plast;
    logic [31:0] pdata;

    modport cam  (input req, wr, addr, wdata, cyc, output ack, err, rdata, pv, plast, pdata);
    modport host (output req, wr, addr, wdata, cyc, input ack, err, rdata, pv, plast, pdata);
endinterface

/* core/cisp_pattern.sv */
// Test image byte generator for four pixels bytes of one link word.
`timescale 1ns/1ps
module cisp_pattern (
    input  wire logic        colour,
    input  wire logic [1:0]  sel,
    input  wire logic        mirror,
    input  wire logic [15:0] width,
    input  wire logic [15:0] row,
    input  wire logic [15:0] col,
    input  wire logic [7:0]  shift,
    output logic      [31:0] word
);
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_byte
            logic [15:0] c;
            logic [7:0]  base;
            logic [7:0]  val;
            always_comb
            begin
                c    = mirror ? 16'(width - 16'h1 - col - 16'(i)) : 16'(col + 16'(i));
                base = 8'(c[7:0] + row[7:0] + shift);
                // Colour parts send raw mosaic samples, red site at even row and column.
                if (!colour)
                    val = base;
                else if (!row[0] && !c[0])
                    val = base; // RL9 RL10
                else if (row[0] && c[0])
                    val = 8'(base >> 2);
                else
                    val = 8'(base >> 1);
                if (sel == 2'h0)
                    val = 8'h00;
            end
            // The first byte on the link is the most significant one.
            assign word[31 - 8 * i -: 8] = val;
        end
    endgenerate
endmodule

/* core/cisp_camera.sv */
// Camera end: register file on the link and isochronous packet framer.
// Behaviour
// RL1 - At most 8192 payload bytes per packet.
// RL2 - Frame ends after 65535 packets at most.
// RL3 - Payload set by host; above 8192 refused.
// RL4 - Payload must be multiple of four bytes.
// RL5 - Bytes per pixel follow pixel format.
// RL6 - Mono image two moves up each frame.
// RL7 - Mono offers two diagonal bars, first static.
// RL8 - Colour offers exactly one test image.
// RL9 - Colour mono_8bit_format sends raw mosaic samples.
// RL10 - Unmirrored colour image starts with red.
// RL11 - Register addresses are 64 bits.
// RL12 - Top bits select bus, then node.
// RL13 - Next 16 bits all ones, low 32 offset.
// RL14 - Registers 32 bits, big endian.
// RL15 - Bit 0 at 614h starts streaming.
// RL16 - Settings change only by register writes.
// RL17 - Offsets relative to control block base.
// RL18 - One packet per bus cycle at most.
`timescale 1ns/1ps
module cisp_camera #(
    parameter bit COLOUR = 1'b0
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    cisp_link_if.cam                        link,
    input  wire logic [cisp_pkg::BUS_W-1:0]  bus_number,
    input  wire logic [cisp_pkg::NODE_W-1:0] node_number,
    output logic                            stream_on,
    output logic                            config_bad
);
    // ==========================================
    // State
    // ==========================================
    typedef struct packed {
        logic        en;
        logic [15:0] width;
        logic [15:0] height;
        logic [15:0] payload;
        logic [2:0]  fmt;
        logic [1:0]  tsel;
        logic        mirror;
        logic        bad;
        logic        ack;
        logic        err;
        logic [31:0] rdata;
        logic        sending;
        logic [31:0] pkt_left;
        logic [31:0] bytes_left;
        logic [15:0] pkts;
        logic [15:0] row;
        logic [15:0] col;
        logic [7:0]  shift;
        logic [15:0] frames;
        logic        pv;
        logic        plast;
        logic [31:0] pdata;
    } cisp_cam_t;

    cisp_cam_t s_q;
    cisp_cam_t s_d;

    logic        hit;
    logic [11:0] ofs;
    logic        cfg_ok;
    logic [31:0] frame_bytes;
    logic [31:0] row_bytes;
    logic [31:0] pkt_bytes;
    logic [31:0] step;
    logic [1:0]  eff_sel;
    logic [7:0]  eff_shift;
    logic [31:0] word;

    // ==========================================
    // Address decode and configuration checks
    // ==========================================
    assign ofs = link.addr[11:0];
    assign hit = link.addr[63:54] == bus_number // RL11 RL12
              && link.addr[53:48] == node_number // RL12
              && link.addr[47:32] == cisp_pkg::ADDR_ONES // RL13
              && link.addr[31:12] == cisp_pkg::CSR_BASE[31:12]; // RL17

    // A bad payload keeps the stream idle rather than sending a broken frame.
    assign cfg_ok = s_q.payload != 16'h0 && s_q.payload[1:0] == 2'h0 // RL4
                 && s_q.payload <= cisp_pkg::MAX_PAYLOAD // RL1 RL3
                 && s_q.width != 16'h0 && s_q.height != 16'h0;

    always_comb
    begin
        logic [34:0] prod;
        prod = 35'(s_q.width) * 35'(s_q.height) * 35'(cisp_pkg::cisp_half_bpp(s_q.fmt)); // RL5
        frame_bytes = 32'(prod >> 1);
        row_bytes   = 32'((19'(s_q.width) * 19'(cisp_pkg::cisp_half_bpp(s_q.fmt))) >> 1);
        pkt_bytes   = (32'(s_q.payload) < s_q.bytes_left) ? 32'(s_q.payload) : s_q.bytes_left;
        step        = (s_q.bytes_left < 32'h4) ? s_q.bytes_left : 32'h4;
    end

    // ==========================================
    // Test image selection
    // ==========================================
    assign eff_sel   = (COLOUR && s_q.tsel != 2'h0) ? 2'h1 : s_q.tsel; // RL8
    assign eff_shift = (!COLOUR && eff_sel == 2'h2) ? s_q.shift : 8'h00; // RL6 RL7

    cisp_pattern u_pattern (
        .colour (COLOUR),
        .sel    (eff_sel),
        .mirror (s_q.mirror),
        .width  (s_q.width),
        .row    (s_q.row),
        .col    (s_q.col),
        .shift  (eff_shift),
        .word   (word)
    );

    // ==========================================
    // Next state
    // ==========================================
    always_comb
    begin
        s_d       = s_q;
        s_d.ack   = 1'b0;
        s_d.pv    = 1'b0;
        s_d.plast = 1'b0;
        s_d.bad   = !cfg_ok;

        // Register access: answered one cycle after the request is seen.
        if (link.req && !s_q.ack)
        begin
            s_d.ack   = 1'b1;
            s_d.err   = 1'b0;
            s_d.rdata = 32'h0;
            if (!hit)
                s_d.err = 1'b1;
            else if (link.wr)
            begin
                case (ofs) // RL16
                    cisp_pkg::OFS_STREAM:  s_d.en = link.wdata[cisp_pkg::BIT_STREAM]; // RL14 RL15
                    cisp_pkg::OFS_WINDOW:
                    begin
                        s_d.width  = link.wdata[31:16];
                        s_d.height = link.wdata[15:0];
                    end
                    cisp_pkg::OFS_PAYLOAD: s_d.payload = link.wdata[15:0];
                    cisp_pkg::OFS_IMAGE:
                    begin
                        s_d.mirror = link.wdata[cisp_pkg::BIT_MIRROR];
                        s_d.tsel   = link.wdata[5:4];
                        s_d.fmt    = link.wdata[2:0];
                    end
                    cisp_pkg::OFS_STATUS:  s_d.err = 1'b0;
                    default:               s_d.err = 1'b1;
                endcase
            end
            else
            begin
                case (ofs)
                    cisp_pkg::OFS_STREAM:  s_d.rdata = {s_q.en, 31'h0}; // RL14
                    cisp_pkg::OFS_WINDOW:  s_d.rdata = {s_q.width, s_q.height};
                    cisp_pkg::OFS_PAYLOAD: s_d.rdata = {16'h0, s_q.payload};
                    cisp_pkg::OFS_IMAGE:
                        s_d.rdata = {s_q.mirror, 25'h0, s_q.tsel, 1'b0, s_q.fmt};
                    cisp_pkg::OFS_STATUS:
                        s_d.rdata = {s_q.bad, s_q.sending, 14'h0, s_q.frames};
                    default:               s_d.err = 1'b1;
                endcase
            end
        end

        // Packet launch on the bus cycle start.
        if (link.cyc && s_q.en && cfg_ok && !s_q.sending) // RL15 RL18
        begin
            s_d.sending = 1'b1;
            if (s_q.bytes_left == 32'h0)
            begin
                s_d.bytes_left = frame_bytes;
                s_d.pkt_left   = (32'(s_q.payload) < frame_bytes) ? 32'(s_q.payload) : frame_bytes;
                s_d.pkts       = 16'h0;
                s_d.row        = 16'h0;
                s_d.col        = 16'h0;
            end
            else
                s_d.pkt_left = pkt_bytes; // RL1
        end

        // One word per clock while a packet is open.
        if (s_q.sending)
        begin
            s_d.pv         = 1'b1;
            s_d.pdata      = word;
            s_d.bytes_left = s_q.bytes_left - step;
            s_d.pkt_left   = (s_q.pkt_left < 32'h4) ? 32'h0 : s_q.pkt_left - 32'h4;
            if (32'(s_q.col) + 32'h4 >= row_bytes)
            begin
                s_d.col = 16'(32'(s_q.col) + 32'h4 - row_bytes);
                s_d.row = 16'(s_q.row + 16'h1);
            end
            else
                s_d.col = 16'(s_q.col + 16'h4);
            if (s_q.pkt_left <= 32'h4 || s_q.bytes_left <= 32'h4)
            begin
                s_d.plast   = 1'b1;
                s_d.sending = 1'b0; // RL18
                s_d.pkts    = 16'(s_q.pkts + 16'h1);
                if (s_q.bytes_left <= 32'h4 || s_d.pkts == cisp_pkg::MAX_PACKETS) // RL2
                begin
                    s_d.bytes_left = 32'h0;
                    s_d.frames     = 16'(s_q.frames + 16'h1);
                    s_d.shift      = 8'(s_q.shift + 8'h1); // RL6
                end
            end
        end
    end

    // ==========================================
    // Registers
    // ==========================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign link.ack   = s_q.ack;
    assign link.err   = s_q.err;
    assign link.rdata = s_q.rdata;
    assign link.pv    = s_q.pv;
    assign link.plast = s_q.plast;
    assign link.pdata = s_q.pdata;
    assign stream_on  = s_q.en;
    assign config_bad = s_q.bad;
endmodule

/* core/cisp_host.sv */
// Host end: APB-programmed register access and bus cycle start generator.
`timescale 1ns/1ps
module cisp_host #(
    parameter int unsigned CYCLE_CLKS = cisp_pkg::CYCLE_CLKS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    cisp_link_if.host        link
);
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        cyc_en;
        logic        wr;
        logic [31:0] addr_lo;
        logic [15:0] node;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        busy;
        logic        done;
        logic        err;
        logic [31:0] words;
        logic [15:0] pkts;
        logic [31:0] timer;
        logic        cyc;
        logic        req;
    } cisp_host_t;

    cisp_host_t s_q;
    cisp_host_t s_d;
    logic       acc;

    // ==========================================
    // Next state
    // ==========================================
    assign acc = psel && penable && !s_q.pready;

    always_comb
    begin
        s_d         = s_q;
        s_d.pready  = acc;
        s_d.pslverr = 1'b0;
        s_d.cyc     = 1'b0;

        if (acc && pwrite)
        begin
            case (paddr)
                cisp_pkg::HOST_CTRL:
                begin
                    s_d.cyc_en = pwdata[cisp_pkg::CTRL_CYC];
                    if (pwdata[cisp_pkg::CTRL_GO] && !s_q.busy)
                    begin
                        s_d.wr   = pwdata[cisp_pkg::CTRL_WR];
                        s_d.busy = 1'b1;
                        s_d.req  = 1'b1;
                        s_d.done = 1'b0;
                    end
                end
                cisp_pkg::HOST_ADDR:  s_d.addr_lo = pwdata;
                cisp_pkg::HOST_WDATA: s_d.wdata   = pwdata;
                cisp_pkg::HOST_NODE:  s_d.node    = pwdata[15:0];
                cisp_pkg::HOST_WORDS:
                begin
                    s_d.words = 32'h0;
                    s_d.pkts  = 16'h0;
                end
                default:              s_d.pslverr = 1'b1;
            endcase
        end
        else if (acc)
        begin
            case (paddr)
                cisp_pkg::HOST_CTRL:   s_d.prdata = {29'h0, s_q.cyc_en, s_q.wr, s_q.busy};
                cisp_pkg::HOST_ADDR:   s_d.prdata = s_q.addr_lo;
                cisp_pkg::HOST_WDATA:  s_d.prdata = s_q.wdata;
                cisp_pkg::HOST_RDATA:  s_d.prdata = s_q.rdata;
                cisp_pkg::HOST_STATUS: s_d.prdata = {s_q.pkts, 13'h0, s_q.err, s_q.done, s_q.busy};
                cisp_pkg::HOST_WORDS:  s_d.prdata = s_q.words;
                cisp_pkg::HOST_NODE:   s_d.prdata = {16'h0, s_q.node};
                default:
                begin
                    s_d.prdata  = 32'h0;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end

        // Link answer ends the request; a new go cannot land while busy.
        if (s_q.req && link.ack)
        begin
            s_d.req   = 1'b0;
            s_d.busy  = 1'b0;
            s_d.done  = 1'b1;
            s_d.err   = link.err;
            s_d.rdata = link.rdata;
        end

        // Bus cycle start strobe every CYCLE_CLKS clocks while enabled, 125 us with the default.
        if (!s_q.cyc_en || s_q.timer == 32'(CYCLE_CLKS - 1))
        begin
            s_d.timer = 32'h0;
            s_d.cyc   = s_q.cyc_en;
        end
        else
            s_d.timer = s_q.timer + 32'h1;

        if (link.pv)
            s_d.words = s_q.words + 32'h1;
        if (link.pv && link.plast)
            s_d.pkts = 16'(s_q.pkts + 16'h1);
    end

    // ==========================================
    // Registers
    // ==========================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign pready     = s_q.pready;
    assign prdata     = s_q.prdata;
    assign pslverr    = s_q.pslverr;
    assign link.req   = s_q.req;
    assign link.wr    = s_q.wr;
    assign link.addr  = {s_q.node, cisp_pkg::ADDR_ONES, s_q.addr_lo};
    assign link.wdata = s_q.wdata;
    assign link.cyc   = s_q.cyc;
endmodule

/* bench/cisp_link_assertions.sv */
// Checker of the link signals between the host end and the camera end.
`timescale 1ns/1ps
module cisp_link_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        req,
    input wire logic        wr,
    input wire logic [63:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        ack,
    input wire logic        err,
    input wire logic [31:0] rdata,
    input wire logic        cyc,
    input wire logic        pv,
    input wire logic        plast,
    input wire logic [31:0] pdata
);
    // ==========================================
    // Word and packet counters
    // ==========================================
    logic [15:0] words_q;
    logic [15:0] words_d;
    logic [1:0]  pkts_q;
    logic [1:0]  pkts_d;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // The packet count saturates so that a runaway stream cannot wrap back to a legal value.
    always_comb
    begin
        words_d = plast ? 16'h0 : words_q + {15'h0, pv};
        pkts_d  = cyc ? {1'b0, plast} : pkts_q + {1'b0, plast & (pkts_q != 2'h3)};
    end
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            words_q <= 16'h0;
            pkts_q  <= 2'h0;
        end
        else
        begin
            words_q <= words_d;
            pkts_q  <= pkts_d;
        end
    // ==========================================
    // Properties
    // ==========================================
    property p_ack_answer;
        $rose(req) |=> ack;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
    property p_ack_cause;
        ack |-> $past(req) && req ##1 !ack;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_answer_hold;
        !ack |-> $stable(rdata) && $stable(err);
    endproperty
    a_answer_hold: assert property (p_answer_hold) else $error("answer moved");
    property p_base;
        ack && (addr[47:32] != 16'hFFFF || addr[31:12] != 20'hF0F00) |-> err;
    endproperty
    a_base: assert property (p_base) else $error("foreign address accepted");
    property p_unmapped;
        ack && !(addr[11:0] inside {12'h614, 12'hA08, 12'hA0C, 12'hA10, 12'hA14}) |-> err;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped offset accepted");
    property p_payload;
        pv |-> words_q < 16'h800;
    endproperty
    a_payload: assert property (p_payload) else $error("packet above 8192 bytes");
    property p_one_pkt;
        pkts_q <= 2'h1;
    endproperty
    a_one_pkt: assert property (p_one_pkt) else $error("two packets in one cycle");
    property p_start;
        $rose(pv) |-> $past(cyc, 2);
    endproperty
    a_start: assert property (p_start) else $error("packet not started by cycle");
    property p_burst;
        pv && !plast |=> pv;
    endproperty
    a_burst: assert property (p_burst) else $error("gap inside packet");
    property p_hold;
        (req && !ack |=> $stable(wdata)) and (!pv |-> $stable(pdata));
    endproperty
    a_hold: assert property (p_hold) else $error("request data or stream word moved");
endmodule

/* bench/camera_iso_stream_packetizer_tb.sv */
// Self-checking testbench joining the host end and the camera end.
`timescale 1ns/1ps
module camera_iso_stream_packetizer_tb;
    localparam int unsigned CYC = 40;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [9:0]  bus_number;
    logic [5:0]  node_number;
    logic        stream_on;
    logic        config_bad;
    int          mismatches;
    int          checks;
    int          pay;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [31:0] mx;
    logic        e;
    logic [15:0] wcnt;
    logic [31:0] exp_q[$];
    logic [31:0] first_q[$];
    logic [2:0]  hb[6];
    cisp_link_if link_bus ();
    cisp_camera cisp_camera_inst (.pclk(pclk), .presetn(presetn), .link(link_bus),
        .bus_number(bus_number), .node_number(node_number), .stream_on(stream_on),
        .config_bad(config_bad));
    cisp_host #(.CYCLE_CLKS(CYC)) cisp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .link(link_bus));
    cisp_link_checker cisp_link_checker_inst (.pclk(pclk), .presetn(presetn), .req(link_bus.req),
        .wr(link_bus.wr), .addr(link_bus.addr), .wdata(link_bus.wdata), .ack(link_bus.ack),
        .err(link_bus.err), .rdata(link_bus.rdata), .cyc(link_bus.cyc), .pv(link_bus.pv),
        .plast(link_bus.plast), .pdata(link_bus.pdata));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ==========================================
    // Tasks
    // ==========================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            mismatches++;
        r = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Cycle strobes stay enabled on every control write; the camera ignores them while idle.
    task automatic link(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic er);
        logic [31:0] s;
        int n;
        apb(1'b1, cisp_pkg::HOST_ADDR, a, r, er);
        apb(1'b1, cisp_pkg::HOST_WDATA, d, r, er);
        apb(1'b1, cisp_pkg::HOST_CTRL, {29'h0, 1'b1, w, 1'b1}, r, er);
        n = 0;
        s = 32'h0;
        while (s[1] !== 1'b1 && n < 20)
        begin
            apb(1'b0, cisp_pkg::HOST_STATUS, 32'h0, s, er);
            n++;
        end
        if (n >= 20)
            mismatches++;
        er = s[2];
        apb(1'b0, cisp_pkg::HOST_RDATA, 32'h0, r, s[0]);
    endtask

    // Streaming is stopped right after the last expected packet, before the next cycle strobe.
    task automatic run(input int nf, input int b, input int p);
        int n;
        for (int f = 0; f < nf; f++)
            for (int k = 0; k < b; k += p)
                exp_q.push_back({k == 0, 15'h0, 16'((((b - k) < p ? b - k : p) + 3) / 4)});
        link(1'b1, 32'hF0F00614, 32'h80000000, rd, e);
        n = 0;
        while (exp_q.size() > 0 && n < 4000)
        begin
            @(posedge pclk);
            n++;
        end
        link(1'b1, 32'hF0F00614, 32'h0, rd, e);
        chk("packets left", 32'h0, exp_q.size());
        $display("stream test done frames %0d bytes %0d payload %0d", nf, b, p);
    endtask

    always @(posedge pclk)
        if (link_bus.pv === 1'b1)
        begin
            if (wcnt == 16'h0 && exp_q.size() > 0 && exp_q[0][31])
                first_q.push_back(link_bus.pdata);
            wcnt = wcnt + 16'h1;
            if (link_bus.plast === 1'b1)
            begin
                if (exp_q.size() > 0)
                begin
                    mx = exp_q.pop_front();
                    chk("packet words", {16'h0, mx[15:0]}, {16'h0, wcnt});
                end
                wcnt = 16'h0;
            end
        end

    initial
    begin
        #1000000;
        mismatches++;
        final_report();
    end

    // ==========================================
    // Main sequence
    // ==========================================
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = 43'h0;
        presetn = 1'b0;
        mismatches = 0;
        checks = 0;
        wcnt = 16'h0;
        hb = '{3'h2, 3'h3, 3'h4, 3'h4, 3'h3, 3'h6};
        seed = xs(32'h62);
        bus_number = seed[9:0];
        node_number = seed[15:10];
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h40, 32'h0, rd, e);
        chk("apb unmapped", 32'h1, {31'h0, e});
        apb(1'b1, cisp_pkg::HOST_NODE, {16'h0, bus_number ^ 10'h1, node_number}, rd, e);
        link(1'b0, 32'hF0F00614, 32'h0, rd, e);
        chk("wrong bus", 32'h1, {31'h0, e});
        apb(1'b1, cisp_pkg::HOST_NODE, {16'h0, bus_number, node_number}, rd, e);
        link(1'b0, 32'h00000614, 32'h0, rd, e);
        chk("wrong base", 32'h1, {31'h0, e});
        link(1'b0, 32'hF0F00700, 32'h0, rd, e);
        chk("unmapped offset", 32'h1, {31'h0, e});
        link(1'b1, 32'hF0F00614, 32'h00000001, rd, e);
        chk("low bit no start", 32'h0, {31'h0, stream_on});
        link(1'b1, 32'hF0F00614, 32'h80000000, rd, e);
        chk("stream on", 32'h1, {31'h0, stream_on});
        link(1'b0, 32'hF0F00614, 32'h0, rd, e);
        chk("enable readback", 32'h80000000, rd);
        link(1'b1, 32'hF0F00614, 32'h0, rd, e);
        $display("register access test done");
        link(1'b1, 32'hF0F00A08, {16'h8, 16'h4}, rd, e);
        link(1'b1, 32'hF0F00A0C, 32'h2004, rd, e);
        chk("payload 8196", 32'h1, {31'h0, config_bad});
        link(1'b1, 32'hF0F00A0C, 32'h12, rd, e);
        chk("payload 18", 32'h1, {31'h0, config_bad});
        link(1'b1, 32'hF0F00A0C, 32'h2000, rd, e);
        chk("payload 8192", 32'h0, {31'h0, config_bad});
        $display("payload limit test done");
        first_q.delete();
        for (int f = 0; f < 6; f++)
        begin
            seed = xs(seed);
            pay = 4 * (1 + seed[2:0]);
            link(1'b1, 32'hF0F00A0C, pay, rd, e);
            link(1'b1, 32'hF0F00A10, {26'h0, 2'h1, 1'b0, 3'(f)}, rd, e);
            run(1 + int'(f == 0), 16 * hb[f], pay);
        end
        chk("frame starts", 32'h7, first_q.size());
        chk("static image", first_q[0], first_q[1]);
        first_q.delete();
        link(1'b1, 32'hF0F00A10, 32'h20, rd, e);
        run(2, 32, pay);
        chk("moving image", 32'h1, {31'h0, first_q[0] !== first_q[1]});
        final_report();
    end
endmodule
